// ---- inc/icd_pkg.sv ----
// icd_pkg: constants for the instruction cache command and debug-read block
// assumes word-aligned ahb-lite single transfers; bit positions are lsb-first
package icd_pkg;
	// geometry
	localparam int SETS = 128;
	localparam int TAG_W = 21;
	localparam int SET_W = 7;
	localparam int OFS_W = 8;
	// register byte offsets
	localparam logic [7:0] OFS_CMD_STATUS = 8'h00;
	localparam logic [7:0] OFS_DEBUG_ADDR = 8'h04;
	localparam logic [7:0] OFS_DEBUG_OUT = 8'h08;
	// command status register fields
	localparam int CMD_LSB = 0;
	localparam int CMD_W = 4;
	localparam int EN_BIT = 0;
	localparam int ERR_LSB = 4;
	localparam int ERR_W = 3;
	localparam logic [3:0] CMD_INV_ALL = 4'h1;
	localparam logic [3:0] CMD_UNLOCK_LINE = 4'h2;
	localparam logic [3:0] CMD_UNLOCK_ALL = 4'h3;
	localparam logic [3:0] CMD_ENABLE = 4'h4;
	localparam logic [3:0] CMD_DISABLE = 4'h5;
	// debug address fields (lsb numbering)
	localparam int DA_ARRAY_BIT = 13;
	localparam int DA_WAY_BIT = 12;
	localparam int DA_SET_LSB = 4;
	localparam int DA_WORD_LSB = 2;
	localparam int ADR_TAG_LSB = 11;
	// tag readout fields (lsb numbering)
	localparam int TR_TAG_LSB = 11;
	localparam int TR_VALID_BIT = 9;
	localparam int TR_LOCK_BIT = 8;
	localparam int TR_LRU_BIT = 7;
	// reset values
	localparam logic [31:0] RST_DEBUG_ADDR = 32'h0000_0000;
	localparam logic RST_ENABLE = 1'b0;
	// ahb privileged bit of hprot
	localparam int HPROT_PRIV_BIT = 1;
endpackage

// ---- rtl/icd_cache_cmd.sv ----
// icd_cache_cmd: two-way instruction cache arrays with command and debug-read logic
// assumes a single ahb-lite master, one system clock and an asynchronous low reset
`timescale 1ns/1ps
`default_nettype none
module icd_cache_cmd (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [3:0] hprot,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// instruction fetch port
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	input wire logic fetch_inhibit,
	output logic fetch_ack,
	output logic fetch_hit,
	output logic [31:0] fetch_data,
	// line fill port from the bus side
	input wire logic fill_req,
	input wire logic [31:0] fill_addr,
	input wire logic [127:0] fill_line,
	input wire logic fill_lock,
	// status
	output logic cache_enabled
);
	import icd_pkg::*;

	typedef struct packed {
		logic ph_valid;
		logic ph_write;
		logic ph_priv;
		logic rd_wait;
		logic [OFS_W-1:0] ph_addr;
		logic [31:0] rdata;
		logic enable;
		logic [31:0] dadr;
		logic fetch_ack;
		logic fetch_hit;
		logic [31:0] fetch_data;
		logic [SETS-1:0][1:0][TAG_W-1:0] tag;
		logic [SETS-1:0][1:0] valid;
		logic [SETS-1:0][1:0] lock;
		logic [SETS-1:0] lru;
		logic [SETS-1:0][1:0][3:0][31:0] data;
	} icd_state_s;

	icd_state_s s_r;
	icd_state_s s_nxt;

	// decoded debug address and unlock-line lookup
	logic [SET_W-1:0] da_set;
	logic da_way;
	logic [1:0] da_word;
	logic [TAG_W-1:0] da_tag;
	logic [1:0] ul_hitw;
	logic [31:0] dbg_word;
	logic wr_cmd;
	logic [CMD_W-1:0] cmd;

	assign da_set = s_r.dadr[DA_SET_LSB +: SET_W];
	assign da_way = s_r.dadr[DA_WAY_BIT];
	assign da_word = s_r.dadr[DA_WORD_LSB +: 2];
	assign da_tag = s_r.dadr[ADR_TAG_LSB +: TAG_W];
	assign wr_cmd = s_r.ph_valid && s_r.ph_write && (s_r.ph_addr == OFS_CMD_STATUS);
	assign cmd = hwdata[CMD_LSB +: CMD_W];

	// unlock-line target located by normal index and compare
	always_comb begin
		for (int w = 0; w < 2; w++) begin
			ul_hitw[w] = s_r.valid[da_set][w] && (s_r.tag[da_set][w] == da_tag);
		end
	end

	// debug readout word: data word or tag plus status
	always_comb begin
		dbg_word = '0;
		if (s_r.dadr[DA_ARRAY_BIT]) begin
			dbg_word = s_r.data[da_set][da_way][da_word];
		end else begin
			dbg_word[TR_TAG_LSB +: TAG_W] = s_r.tag[da_set][da_way];
			dbg_word[TR_VALID_BIT] = s_r.valid[da_set][da_way];
			dbg_word[TR_LOCK_BIT] = s_r.lock[da_set][da_way];
			dbg_word[TR_LRU_BIT] = s_r.lru[da_set];
		end
	end

	// next state: bus phases, fetch, fill and commands
	always_comb begin
		logic [SET_W-1:0] fset;
		logic [TAG_W-1:0] ftag;
		logic [1:0] fhit;
		logic vic;
		logic vic_ok;
		fset = '0;
		ftag = '0;
		fhit = '0;
		vic = 1'b0;
		vic_ok = 1'b0;
		s_nxt = s_r;
		s_nxt.fetch_ack = 1'b0;
		s_nxt.fetch_hit = 1'b0;
		// instruction fetch lookup, one cycle answer
		if (fetch_req) begin
			fset = fetch_addr[DA_SET_LSB +: SET_W];
			ftag = fetch_addr[ADR_TAG_LSB +: TAG_W];
			for (int w = 0; w < 2; w++) begin
				fhit[w] = s_r.valid[fset][w] && (s_r.tag[fset][w] == ftag);
			end
			s_nxt.fetch_ack = 1'b1;
			if (s_r.enable && !fetch_inhibit && (|fhit)) begin
				s_nxt.fetch_hit = 1'b1;
				s_nxt.fetch_data = s_r.data[fset][fhit[1]][fetch_addr[DA_WORD_LSB +: 2]];
				s_nxt.lru[fset] = ~fhit[1];
			end
		end
		// line fill: invalid way first, else lru, never a locked way
		if (fill_req) begin
			fset = fill_addr[DA_SET_LSB +: SET_W];
			if (!s_r.valid[fset][0]) begin
				vic = 1'b0;
			end else if (!s_r.valid[fset][1]) begin
				vic = 1'b1;
			end else begin
				vic = s_r.lru[fset];
			end
			vic_ok = !s_r.lock[fset][vic];
			if (!vic_ok && !s_r.lock[fset][~vic]) begin
				vic = ~vic;
				vic_ok = 1'b1;
			end
			if (vic_ok) begin
				s_nxt.tag[fset][vic] = fill_addr[ADR_TAG_LSB +: TAG_W];
				s_nxt.valid[fset][vic] = 1'b1;
				s_nxt.lock[fset][vic] = fill_lock;
				s_nxt.lru[fset] = ~vic;
				for (int k = 0; k < 4; k++) begin
					s_nxt.data[fset][vic][k] = fill_line[32*k +: 32];
				end
			end
		end
		// write data phase
		if (s_r.ph_valid && s_r.ph_write) begin
			if (s_r.ph_addr == OFS_DEBUG_ADDR) begin
				s_nxt.dadr = hwdata;
			end
			if (wr_cmd && s_r.ph_priv) begin
				unique case (cmd)
					CMD_ENABLE: s_nxt.enable = 1'b1;
					CMD_DISABLE: s_nxt.enable = 1'b0;
					CMD_UNLOCK_LINE: begin
						for (int w = 0; w < 2; w++) begin
							if (ul_hitw[w]) begin
								s_nxt.lock[da_set][w] = 1'b0;
							end
						end
					end
					CMD_UNLOCK_ALL: s_nxt.lock = '0;
					CMD_INV_ALL: begin
						for (int i = 0; i < SETS; i++) begin
							for (int w = 0; w < 2; w++) begin
								if (!s_nxt.lock[i][w]) begin
									s_nxt.valid[i][w] = 1'b0;
								end
							end
							if (s_nxt.lock[i] != 2'b11) begin
								s_nxt.lru[i] = s_nxt.lock[i][0];
							end
						end
					end
					default: s_nxt.enable = s_r.enable;
				endcase
			end
		end
		// read data phase: one wait cycle, then registered data
		if (s_r.ph_valid && !s_r.ph_write && s_r.rd_wait) begin
			s_nxt.rd_wait = 1'b0;
			unique case (s_r.ph_addr)
				OFS_CMD_STATUS: begin
					s_nxt.rdata = '0;
					s_nxt.rdata[EN_BIT] = s_r.enable;
				end
				OFS_DEBUG_ADDR: s_nxt.rdata = s_r.dadr;
				OFS_DEBUG_OUT: s_nxt.rdata = dbg_word;
				default: s_nxt.rdata = '0;
			endcase
		end else if (hready) begin
			// address phase
			s_nxt.ph_valid = hsel && htrans[1];
			s_nxt.ph_write = hwrite;
			s_nxt.ph_priv = hprot[HPROT_PRIV_BIT];
			s_nxt.ph_addr = haddr[OFS_W-1:0];
			s_nxt.rd_wait = hsel && htrans[1] && !hwrite;
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.dadr <= RST_DEBUG_ADDR;
			s_r.enable <= RST_ENABLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs
	assign hreadyout = !(s_r.ph_valid && !s_r.ph_write && s_r.rd_wait);
	assign hresp = 1'b0;
	assign hrdata = s_r.rdata;
	assign fetch_ack = s_r.fetch_ack;
	assign fetch_hit = s_r.fetch_hit;
	assign fetch_data = s_r.fetch_data;
	assign cache_enabled = s_r.enable;

	// helper view for checks
	logic any_unlocked_valid;
	always_comb begin
		any_unlocked_valid = 1'b0;
		for (int i = 0; i < SETS; i++) begin
			any_unlocked_valid = any_unlocked_valid | (|(s_r.valid[i] & ~s_r.lock[i]));
		end
	end

	// helper view: lru naming a locked way, or way one with both free
	logic lru_bad;
	always_comb begin
		lru_bad = 1'b0;
		for (int i = 0; i < SETS; i++) begin
			if (s_r.lock[i] == 2'b00) begin
				lru_bad = lru_bad | s_r.lru[i];
			end else if (s_r.lock[i] != 2'b11) begin
				lru_bad = lru_bad | s_r.lock[i][s_r.lru[i]];
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// checks
	a_read_one_wait: assert property (
		(hsel && hready && htrans[1] && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read did not take exactly one wait cycle");
	a_write_no_wait: assert property (
		(s_r.ph_valid && s_r.ph_write) |-> hreadyout)
		else $error("write data phase stalled");
	a_enable_cmd: assert property (
		(wr_cmd && s_r.ph_priv && cmd == CMD_ENABLE) |=> cache_enabled)
		else $error("enable command not honoured");
	a_disable_cmd: assert property (
		(wr_cmd && s_r.ph_priv && cmd == CMD_DISABLE) |=> !cache_enabled)
		else $error("disable command not honoured");
	a_user_ignored: assert property (
		(wr_cmd && !s_r.ph_priv) |=> $stable(cache_enabled))
		else $error("user write changed enable");
	a_inhibit_miss: assert property (
		(fetch_req && fetch_inhibit) |=> (fetch_ack && !fetch_hit))
		else $error("inhibited fetch reported a hit");
	a_unlock_all: assert property (
		(wr_cmd && s_r.ph_priv && cmd == CMD_UNLOCK_ALL && !fill_req) |=> (s_r.lock == '0))
		else $error("lock left after unlock all");
	a_unlock_miss: assert property (
		(wr_cmd && s_r.ph_priv && cmd == CMD_UNLOCK_LINE && ul_hitw == 2'b00 && !fill_req)
		|=> $stable(s_r.lock))
		else $error("unlock line miss changed locks");
	a_unlock_hit: assert property (
		(wr_cmd && s_r.ph_priv && cmd == CMD_UNLOCK_LINE && ul_hitw[0] && !fill_req)
		|=> !s_r.lock[$past(da_set)][0])
		else $error("unlock line hit kept lock");
	a_inval_all: assert property (
		(wr_cmd && s_r.ph_priv && cmd == CMD_INV_ALL && !fill_req) |=> !any_unlocked_valid)
		else $error("unlocked valid line survived invalidate all");
	a_no_error: assert property (
		(s_r.ph_valid && !s_r.ph_write && !s_r.rd_wait && s_r.ph_addr == OFS_CMD_STATUS)
		|-> (hrdata[ERR_LSB +: ERR_W] == '0))
		else $error("error bit reported");
	a_tag_reserved: assert property (
		(s_r.ph_valid && !s_r.ph_write && s_r.rd_wait && s_r.ph_addr == OFS_DEBUG_OUT
		&& !s_r.dadr[DA_ARRAY_BIT]) |=> (hrdata[10] == 1'b0 && hrdata[6:0] == '0))
		else $error("reserved tag readout bits set");

	// lock, lru and debug address checks
	a_locked_valid: assert property (
		((s_r.lock & ~s_r.valid) == '0))
		else $error("locked line found invalid");
	a_inval_lru: assert property (
		(wr_cmd && s_r.ph_priv && cmd == CMD_INV_ALL && !fill_req) |=> !lru_bad)
		else $error("lru left on a locked way after invalidate all");
	a_user_locks: assert property (
		(wr_cmd && !s_r.ph_priv && !fill_req) |=> $stable(s_r.lock))
		else $error("user command changed locks");
	a_dadr_write: assert property (
		(s_r.ph_valid && s_r.ph_write && s_r.ph_addr == OFS_DEBUG_ADDR)
		|=> (s_r.dadr == $past(hwdata)))
		else $error("debug address write lost");

	// fetch port checks
	a_fetch_answer: assert property (
		fetch_req |=> fetch_ack)
		else $error("fetch not answered next cycle");
	a_fetch_quiet: assert property (
		!fetch_req |=> !fetch_ack)
		else $error("fetch answer without request");
	a_disabled_miss: assert property (
		(fetch_req && !cache_enabled) |=> !fetch_hit)
		else $error("disabled cache reported a hit");

	// scenarios
	c_fetch_hit: cover property (fetch_ack && fetch_hit);
	c_dbg_read: cover property (s_r.ph_valid && !s_r.ph_write && !s_r.rd_wait
		&& s_r.ph_addr == OFS_DEBUG_OUT);
	c_unlock_hit: cover property (wr_cmd && s_r.ph_priv && cmd == CMD_UNLOCK_LINE && |ul_hitw);
	c_user_reject: cover property (wr_cmd && !s_r.ph_priv);
	c_inval_all: cover property (wr_cmd && s_r.ph_priv && cmd == CMD_INV_ALL);
endmodule
`default_nettype wire

// ---- test/icd_fill_model.sv ----
// icd_fill_model: line fill side standing in for the bus interface of the cache
// assumes one go pulse per line from the bench; word k of a line is base plus k
`timescale 1ns/1ps
`default_nettype none
module icd_fill_model (
	// clock and request from the bench
	input wire logic hclk,
	input wire logic go,
	input wire logic [20:0] tag,
	input wire logic [6:0] set,
	input wire logic lock,
	input wire logic [31:0] base,
	// fill port toward the cache
	output logic fill_req,
	output logic [31:0] fill_addr,
	output logic [127:0] fill_line,
	output logic fill_lock
);
	// quiet start so the cache never sees unknowns
	initial begin
		fill_req = 1'b0;
		fill_addr = 32'h0;
		fill_line = 128'h0;
		fill_lock = 1'b0;
	end
	// one-cycle fill pulse; between fills the lines toggle so stale values never look valid
	always @(posedge hclk) begin
		fill_req <= go;
		fill_lock <= go ? lock : ~fill_lock;
		fill_addr <= go ? {tag, set, 4'h0} : ~fill_addr;
		fill_line <= go ? {base + 32'h3, base + 32'h2, base + 32'h1, base} : ~fill_line;
	end
endmodule
`default_nettype wire

// ---- test/icache_command_debug_read_bench.sv ----
// icache_command_debug_read_bench: self-checking bench for the cache command block
// assumes a 250 MHz clock, one ahb-lite master here and the fill model on the fill port
`timescale 1ns/1ps
`default_nettype none
module icache_command_debug_read_bench;
	import icd_pkg::*;
	localparam logic [20:0] TA = 21'h0ABCD;
	localparam logic [20:0] TB = 21'h01234;
	localparam logic [95:0] ROWS [0:6] = '{
		{32'h0000_2050, 32'hFFFF_FFFF, 32'hA5A5_0000},
		{32'h0000_205C, 32'hFFFF_FFFF, 32'hA5A5_0003},
		{32'h0000_0050, 32'hFFFF_FFFF, {TA, 11'h380}},
		{32'h0000_1050, 32'h0000_07FF, 32'h0000_0080},
		{32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000},
		{32'h0000_1000, 32'hFFFF_FFFF, 32'h0000_0000},
		{32'h0000_3058, 32'hFFFF_FFFF, 32'hB0B0_0002}};
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [1:0] htrans = 2'h0;
	logic [3:0] hprot = 4'h0;
	logic fetch_req = 1'b0, fetch_inhibit = 1'b0, go = 1'b0, glock = 1'b0;
	logic [31:0] fetch_addr = 32'h0, gbase = 32'h0;
	logic [20:0] gtag = 21'h0;
	logic [6:0] gset = 7'h0;
	logic hreadyout, hresp, fetch_ack, fetch_hit, cache_enabled, fill_req, fill_lock;
	logic [31:0] hrdata, fetch_data, fill_addr;
	logic [127:0] fill_line;
	int bad_count = 0, cmp_count = 0;
	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	always #2 hclk = ~hclk;
	icd_cache_cmd dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hprot(hprot), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_inhibit(fetch_inhibit), .fetch_ack(fetch_ack),
		.fetch_hit(fetch_hit), .fetch_data(fetch_data), .fill_req(fill_req),
		.fill_addr(fill_addr), .fill_line(fill_line), .fill_lock(fill_lock),
		.cache_enabled(cache_enabled));
	icd_fill_model fm (.hclk(hclk), .go(go), .tag(gtag), .set(gset), .lock(glock), .base(gbase),
		.fill_req(fill_req), .fill_addr(fill_addr),
		.fill_line(fill_line), .fill_lock(fill_lock));
	// verdict and end of run
	task automatic conclude();
		if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one ahb-lite single transfer; read data lands in q
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic pv);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hprot <= {2'h0, pv, 1'b1};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	// fetch lookup, answer registered on the edge that takes the request and checked just after it
	task automatic fetch(input logic [31:0] a, input logic inh, input logic h, input logic [31:0] d);
		@(posedge hclk);
		fetch_req <= 1'b1;
		fetch_addr <= a;
		fetch_inhibit <= inh;
		@(posedge hclk);
		fetch_req <= 1'b0;
		#1;
		chk({30'h0, fetch_ack, fetch_hit}, {30'h0, 1'b1, h});
		if (h) chk(fetch_data, d);
	endtask
	// line fill through the far-side model
	task automatic fill(input logic [20:0] t, input logic [6:0] s, input logic l, input logic [31:0] b);
		@(posedge hclk);
		go <= 1'b1;
		gtag <= t;
		gset <= s;
		glock <= l;
		gbase <= b;
		@(posedge hclk);
		go <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	// debug read: set address, read it back, read masked readout
	task automatic dbg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(OFS_DEBUG_ADDR, 1'b1, a, 1'b1);
		bus(OFS_DEBUG_ADDR, 1'b0, 32'h0, 1'b1);
		chk(q, a);
		bus(OFS_DEBUG_OUT, 1'b0, 32'h0, 1'b1);
		chk(q & m, e);
	endtask
	// command write and status check
	task automatic cmd(input logic [3:0] c, input logic pv, input logic en);
		bus(OFS_CMD_STATUS, 1'b1, {28'h0, c}, pv);
		bus(OFS_CMD_STATUS, 1'b0, 32'h0, 1'b1);
		chk(q, {31'h0, en});
		chk({31'h0, cache_enabled}, {31'h0, en});
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk({31'h0, cache_enabled}, {31'h0, RST_ENABLE});
		bus(OFS_DEBUG_ADDR, 1'b0, 32'h0, 1'b1);
		chk(q, RST_DEBUG_ADDR);
		cmd(CMD_INV_ALL, 1'b1, 1'b0);
		cmd(CMD_UNLOCK_ALL, 1'b1, 1'b0);
		fetch(32'h0, 1'b0, 1'b0, 32'h0);
		cmd(CMD_ENABLE, 1'b1, 1'b1);
		fill(TA, 7'd5, 1'b1, 32'hA5A5_0000);
		fill(TB, 7'd5, 1'b0, 32'hB0B0_0000);
		cmd(CMD_INV_ALL, 1'b1, 1'b1);
		for (int i = 0; i < 7; i++) begin
			dbg(ROWS[i][95:64], ROWS[i][63:32], ROWS[i][31:0]);
		end
		bus(8'h0C, 1'b0, 32'h0, 1'b1);
		chk(q, 32'h0);
		fetch({TA, 7'd5, 4'h4}, 1'b0, 1'b1, 32'hA5A5_0001);
		fetch({TA, 7'd5, 4'h4}, 1'b1, 1'b0, 32'h0);
		fetch({TB, 7'd5, 4'h4}, 1'b0, 1'b0, 32'h0);
		bus(OFS_DEBUG_ADDR, 1'b1, {TB, 7'd5, 4'h0}, 1'b1);
		cmd(CMD_UNLOCK_LINE, 1'b1, 1'b1);
		dbg(32'h0000_0050, 32'h0000_0300, 32'h0000_0300);
		bus(OFS_DEBUG_ADDR, 1'b1, {TA, 7'd5, 4'h0}, 1'b1);
		cmd(CMD_UNLOCK_LINE, 1'b0, 1'b1);
		dbg(32'h0000_0050, 32'h0000_0300, 32'h0000_0300);
		bus(OFS_DEBUG_ADDR, 1'b1, {TA, 7'd5, 4'h0}, 1'b1);
		cmd(CMD_UNLOCK_LINE, 1'b1, 1'b1);
		dbg(32'h0000_0050, 32'h0000_0300, 32'h0000_0200);
		fill(21'h1F00F, 7'd6, 1'b1, 32'hC3C3_0000);
		cmd(CMD_UNLOCK_ALL, 1'b1, 1'b1);
		dbg(32'h0000_0060, 32'h0000_0300, 32'h0000_0200);
		dbg(32'h0000_1060, 32'h0000_0300, 32'h0000_0000);
		cmd(4'h7, 1'b1, 1'b1);
		dbg(32'h0000_0050, 32'h0000_0300, 32'h0000_0200);
		cmd(CMD_DISABLE, 1'b0, 1'b1);
		cmd(CMD_DISABLE, 1'b1, 1'b0);
		fetch({TA, 7'd5, 4'h4}, 1'b0, 1'b0, 32'h0);
		cmd(CMD_ENABLE, 1'b0, 1'b0);
		cmd(CMD_ENABLE, 1'b1, 1'b1);
		// mid-run reset: enable, debug address and arrays back to zero
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({29'h0, hreadyout, fetch_ack, cache_enabled}, {29'h0, 1'b1, 1'b0, RST_ENABLE});
		hresetn <= 1'b1;
		bus(OFS_DEBUG_ADDR, 1'b0, 32'h0, 1'b1);
		chk(q, RST_DEBUG_ADDR);
		dbg(32'h0000_0050, 32'hFFFF_FFFF, 32'h0000_0000);
		cmd(CMD_INV_ALL, 1'b1, 1'b0);
		conclude();
	end
	// watchdog against a hung handshake
	initial begin
		#40000;
		bad_count++;
		conclude();
	end
endmodule
`default_nettype wire
